/* design/sas_cfg.svh */
// Offsets, field positions, reset values and timing counts of the sequencer
`ifndef SAS_CFG_SVH
`define SAS_CFG_SVH
`define SAS_OFF_CTRL    12'h060
`define SAS_OFF_STAT    12'h064
`define SAS_OFF_CFG0    12'h06c
`define SAS_OFF_CFG1    12'h070
`define SAS_OFF_CFG2    12'h074
`define SAS_OFF_CFG3    12'h078
`define SAS_OFF_CFG4    12'h07c
`define SAS_BUF_BASE    12'h400
`define SAS_BUF_END     12'h900
`define SAS_CTRL_OVR    0
`define SAS_CTRL_EN     1
`define SAS_CTRL_RATE   2
`define SAS_CTRL_PAIR   4
`define SAS_CTRL_SE     7
`define SAS_CTRL_NEG    8
`define SAS_CTRL_M256   9
`define SAS_CTRL_RST    32'h0000_0001
`define SAS_CFG_RST     32'h0000_0000
`define SAS_CH_ST       0
`define SAS_CH_EN       4
`define SAS_CH_DIFF     5
`define SAS_CH_SHOT     6
`define SAS_NCH         10
`define SAS_CLK_HZ      40000000
`define SAS_T_HZ        1280000
`define SAS_RATE0_HZ    80000
`define SAS_RATE1_HZ    160000
`define SAS_RATE2_HZ    320000
`define SAS_ST_BASE320  2
`define SAS_ST_BASE256  3
`define SAS_T_CYC       ((`SAS_CLK_HZ + `SAS_T_HZ - 1) / `SAS_T_HZ)
`define SAS_P0_CYC      (`SAS_CLK_HZ / `SAS_RATE0_HZ)
`define SAS_P1_CYC      (`SAS_CLK_HZ / `SAS_RATE1_HZ)
`define SAS_P2_CYC      (`SAS_CLK_HZ / `SAS_RATE2_HZ)
`define SAS_FIFO_DEPTH  16
`endif

/* design/sas_pkg.sv */
// Types of the converter sequencer
package sas_pkg;
	typedef enum logic [1:0] {
		SAS_IDLE = 2'b00,
		SAS_SAMP = 2'b01,
		SAS_CONV = 2'b10
	} sas_state_t;
endpackage

/* design/sas_top.sv */
// Converter sequencer top with its result FIFO
// What this block does
// RULE_01 - Reset leaves manual mode selected with differential conversion.
// RULE_02 - Manual mode paces conversions at 80k, 160k or 320k samples/s.
// RULE_03 - Manual mode converts one pair, differential or positive/negative single-ended.
// RULE_04 - When enabled, convert repeatedly and store into the channel's buffer.
// RULE_05 - Each channel has a 128-byte buffer; full sets its status flag.
// RULE_06 - Each 12-bit result takes two bytes; sixty-four samples per buffer.
// RULE_07 - Override bit at 0 selects auto sweep mode.
// RULE_08 - Auto sweep visits enabled channels in order without software action.
// RULE_09 - Ten channels each have sample time, enable, diff and one-shot.
// RULE_10 - Auto sweep stores into the same per-channel buffers as manual.
// RULE_11 - At 320k maximum the sample field gives 2T to 62T, 4T steps.
// RULE_12 - At 256k maximum it gives 3T to 63T; T is 1.28MHz period.
// RULE_13 - Channel field bit 4 enables, bit 5 chooses differential.
// RULE_14 - Bit 6 chooses one-shot; channel fields act in auto sweep only.
// RULE_15 - First word: temperature channel high half, PGA channel low half.
// RULE_16 - Second word: input A negative high, A positive/differential low.
// RULE_17 - Third word: input B negative high, B positive/differential low.
// RULE_18 - Ten inputs: two PGA, two temperature sensor, six general.
// RULE_19 - Results sit right-aligned in their slot, upper four bits zero.
//
// Implementation choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "sas_cfg.svh"

module sas_fifo #(
	parameter int W = 16,
	parameter int D = 16
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW:0]  wp_r;
	logic [AW:0]  rp_r;
	wire          push = in_valid && in_ready;
	wire          pop  = out_valid && out_ready;

	assign in_ready  = !((wp_r[AW] != rp_r[AW]) &&
		(wp_r[AW-1:0] == rp_r[AW-1:0]));
	assign out_valid = (wp_r != rp_r);
	assign out_data  = mem[rp_r[AW-1:0]];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_r[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			wp_r <= wp_r + (AW+1)'(push);
			rp_r <= rp_r + (AW+1)'(pop);
		end
	end
endmodule // sas_fifo

module sas_top (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic [11:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic             conv_sample,
	output logic             conv_start,
	output logic      [3:0]  conv_chan,
	output logic             conv_diff,
	output logic             conv_neg,
	input  wire logic        conv_done,
	input  wire logic [11:0] conv_data,
	output logic      [9:0]  buf_full
);
	localparam int NCH = `SAS_NCH;
	localparam logic [11:0] TCYC = 12'(`SAS_T_CYC);

	sas_pkg::sas_state_t state_r;
	sas_pkg::sas_state_t state_nxt;
	logic [31:0] ctrl_r;
	logic [31:0] cfg_r [5];
	logic [9:0]  full_r;
	logic [9:0]  full_nxt;
	logic [5:0]  ptr_r [NCH];
	logic [9:0]  shot_r;
	logic [9:0]  shot_nxt;
	logic [11:0] samp_cnt_r;
	logic [8:0]  pace_cnt_r;
	logic        pace_req_r;
	logic [3:0]  cur_ch_r;
	logic [3:0]  next_ch;
	logic        next_ok;
	logic [11:0] buf_mem [640];
	logic [31:0] rdata_r;
	logic        samp_r;
	logic        start_r;
	logic [3:0]  chan_r;
	logic        diff_r;
	logic        neg_r;

	// Register decode
	wire hit_ctrl = (reg_addr == `SAS_OFF_CTRL);
	wire hit_stat = (reg_addr == `SAS_OFF_STAT);
	wire hit_buf  = (reg_addr >= `SAS_BUF_BASE) && (reg_addr < `SAS_BUF_END);
	wire [10:0] buf_off = 11'(reg_addr - `SAS_BUF_BASE);
	wire [9:0]  rd_idx0 = {buf_off[10:2], 1'b0};
	wire [9:0]  rd_idx1 = {buf_off[10:2], 1'b1};
	logic [2:0] cfg_sel;
	logic       hit_cfg;
	always_comb begin
		hit_cfg = 1'b1;
		cfg_sel = 3'd0;
		case (reg_addr)
			`SAS_OFF_CFG0: cfg_sel = 3'd0; // [RULE_15]
			`SAS_OFF_CFG1: cfg_sel = 3'd1; // [RULE_16]
			`SAS_OFF_CFG2: cfg_sel = 3'd2; // [RULE_17]
			`SAS_OFF_CFG3: cfg_sel = 3'd3;
			`SAS_OFF_CFG4: cfg_sel = 3'd4;
			default:       hit_cfg = 1'b0;
		endcase
	end

	// Samples right-aligned, upper bits zero; two per word
	wire [31:0] buf_word = {4'h0, buf_mem[rd_idx1],
		4'h0, buf_mem[rd_idx0]}; // [RULE_19] [RULE_06]
	wire [31:0] rdata_nxt = !reg_rd ? 32'h0 :
		hit_ctrl ? ctrl_r :
		hit_stat ? {22'h0, full_r} :
		hit_cfg  ? cfg_r[cfg_sel] :
		hit_buf  ? buf_word : 32'h0;

	// Control fields
	wire       ovr     = ctrl_r[`SAS_CTRL_OVR];
	wire       run     = ctrl_r[`SAS_CTRL_EN];
	wire [1:0] rate    = ctrl_r[`SAS_CTRL_RATE +: 2];
	wire [2:0] pair    = ctrl_r[`SAS_CTRL_PAIR +: 3];
	wire       man_se  = ctrl_r[`SAS_CTRL_SE];
	wire       man_neg = ctrl_r[`SAS_CTRL_NEG];
	wire       m256    = ctrl_r[`SAS_CTRL_M256];
	wire       auto_md = !ovr; // [RULE_07]

	// Per-channel fields: even index positive/diff, odd negative
	logic [15:0] ch_cfg [NCH];
	logic [9:0]  ch_en;
	logic [9:0]  ch_shot;
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			assign ch_cfg[g]  = cfg_r[g/2][(g%2)*16 +: 16]; // [RULE_09] [RULE_18]
			assign ch_en[g]   = ch_cfg[g][`SAS_CH_EN]; // [RULE_13]
			assign ch_shot[g] = ch_cfg[g][`SAS_CH_SHOT]; // [RULE_14]
		end
	endgenerate
	wire [9:0] ch_live = ch_en & ~shot_r;

	// Next live channel (enabled, one-shot not yet fired) after the current one, wrapping
	always_comb begin
		int   k;
		logic [4:0] idx;
		k = 0;
		next_ch = 4'd0;
		next_ok = 1'b0;
		idx = 5'd0;
		for (k = NCH; k >= 1; k--) begin
			idx = 5'(cur_ch_r) + 5'(k);
			if (idx >= 5'(NCH)) begin
				idx = idx - 5'(NCH);
			end
			if (ch_live[idx[3:0]]) begin
				next_ch = idx[3:0]; // [RULE_08]
				next_ok = 1'b1;
			end
		end
	end

	// Manual channel: pair picks slot, negative single-ended the odd slot
	wire [3:0] man_ch = {pair, 1'b0} + {3'd0, man_se & man_neg}; // [RULE_03]
	wire [3:0] sel_ch = auto_md ? next_ch : man_ch;
	wire       sel_diff = auto_md ? ch_cfg[next_ch][`SAS_CH_DIFF] : !man_se;
	wire       sel_neg  = auto_md ? next_ch[0] : (man_se & man_neg);

	// Sample time in T units; auto uses channel field, manual the minimum
	wire [3:0] st_fld = auto_md ? ch_cfg[next_ch][`SAS_CH_ST +: 4] : 4'h0;
	wire [5:0] st_base = m256 ? 6'(`SAS_ST_BASE256) : 6'(`SAS_ST_BASE320);
	wire [5:0] st_units = {st_fld, 2'b00} + st_base; // [RULE_11] [RULE_12]
	wire [11:0] st_cyc = 12'(st_units) * TCYC;

	wire [8:0] pace_len = (rate == 2'd0) ? 9'(`SAS_P0_CYC) :
		(rate == 2'd1) ? 9'(`SAS_P1_CYC) : 9'(`SAS_P2_CYC); // [RULE_02]

	// FIFO between converter and buffers
	logic        f_in_ready;
	logic        f_out_valid;
	logic [15:0] f_out_data;
	wire         f_push = (state_r == sas_pkg::SAS_CONV) && conv_done;
	wire [3:0]   d_ch = f_out_data[15:12];
	wire         d_ready = !full_r[d_ch];
	wire         d_pop = f_out_valid && d_ready;

	sas_fifo #(.W(16), .D(`SAS_FIFO_DEPTH)) u_fifo (
		.clk       (ref_clk),
		.rst_n     (rst_n),
		.in_valid  (f_push),
		.in_ready  (f_in_ready),
		.in_data   ({chan_r, conv_data}),
		.out_valid (f_out_valid),
		.out_ready (d_ready),
		.out_data  (f_out_data)
	);

	wire go_man  = ovr && run && pace_req_r;
	wire go_auto = auto_md && run && next_ok;
	wire go      = (go_man || go_auto) && f_in_ready; // [RULE_04]

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			sas_pkg::SAS_IDLE: begin
				if (go) begin
					state_nxt = sas_pkg::SAS_SAMP;
				end
			end
			sas_pkg::SAS_SAMP: begin
				if (samp_cnt_r <= 12'd1) begin
					state_nxt = sas_pkg::SAS_CONV;
				end
			end
			sas_pkg::SAS_CONV: begin
				if (conv_done) begin
					state_nxt = sas_pkg::SAS_IDLE;
				end
			end
			default: state_nxt = sas_pkg::SAS_IDLE;
		endcase
	end

	// Full flags: set wins over a write-one clear
	wire       wr_stat = reg_wr && hit_stat;
	wire [9:0] drain_last = (d_pop && ptr_r[d_ch] == 6'd63) ?
		10'(1) << d_ch : 10'h0;
	assign full_nxt = (full_r & ~(wr_stat ? reg_wdata[9:0] : 10'h0)) |
		drain_last; // [RULE_05]

	// One-shot channels drop out until re-enabled or manual is chosen
	wire [9:0] shot_set = (f_push && auto_md && ch_shot[chan_r]) ?
		10'(1) << chan_r : 10'h0;
	assign shot_nxt = (shot_r | shot_set) & ch_en & {10{auto_md}}; // [RULE_14]

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= `SAS_CTRL_RST; // [RULE_01]
			for (int i = 0; i < 5; i++) begin
				cfg_r[i] <= `SAS_CFG_RST;
			end
		end else if (reg_wr && hit_ctrl) begin
			ctrl_r <= reg_wdata;
		end else if (reg_wr && hit_cfg) begin
			cfg_r[cfg_sel] <= reg_wdata;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pace_cnt_r <= 9'd0;
			pace_req_r <= 1'b0;
		end else if (!(ovr && run)) begin
			pace_cnt_r <= 9'd0;
			pace_req_r <= 1'b0;
		end else if (pace_cnt_r == 9'd0) begin
			pace_cnt_r <= pace_len - 9'd1;
			pace_req_r <= 1'b1;
		end else begin
			pace_cnt_r <= pace_cnt_r - 9'd1;
			if (state_r == sas_pkg::SAS_IDLE && go) begin
				pace_req_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r    <= sas_pkg::SAS_IDLE;
			samp_cnt_r <= 12'd0;
			cur_ch_r   <= 4'd9;
			samp_r     <= 1'b0;
			start_r    <= 1'b0;
			chan_r     <= 4'd0;
			diff_r     <= 1'b1;
			neg_r      <= 1'b0;
		end else begin
			state_r <= state_nxt;
			start_r <= (state_r == sas_pkg::SAS_SAMP) &&
				(state_nxt == sas_pkg::SAS_CONV);
			if (state_r == sas_pkg::SAS_IDLE && go) begin
				samp_cnt_r <= st_cyc;
				samp_r     <= 1'b1;
				chan_r     <= sel_ch; // [RULE_10]
				diff_r     <= sel_diff; // [RULE_13]
				neg_r      <= sel_neg;
				if (auto_md) begin
					cur_ch_r <= next_ch;
				end
			end else if (state_r == sas_pkg::SAS_SAMP) begin
				samp_cnt_r <= samp_cnt_r - 12'd1;
				samp_r     <= (state_nxt == sas_pkg::SAS_SAMP);
			end
		end
	end

	// Drain FIFO into channel buffers, two bytes per sample
	generate
		for (g = 0; g < NCH; g++) begin : g_ptr
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					ptr_r[g] <= 6'd0;
				end else if (d_pop && d_ch == 4'(g)) begin
					ptr_r[g] <= ptr_r[g] + 6'd1; // [RULE_06]
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk) begin
		if (d_pop) begin
			buf_mem[{d_ch, ptr_r[d_ch]}] <= f_out_data[11:0]; // [RULE_04]
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			full_r  <= 10'h0;
			shot_r  <= 10'h0;
			rdata_r <= 32'h0;
		end else begin
			full_r  <= full_nxt;
			shot_r  <= shot_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata   = rdata_r;
	assign conv_sample = samp_r;
	assign conv_start  = start_r;
	assign conv_chan   = chan_r;
	assign conv_diff   = diff_r;
	assign conv_neg    = neg_r;
	assign buf_full    = full_r;
endmodule // sas_top
`default_nettype wire

/* bench/sas_conv_model.sv */
// Behavioural converter core that answers start pulses
`timescale 1ns/100ps
`default_nettype none
module sas_conv_model (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        conv_start,
	input  wire logic        slow,
	output logic             conv_done,
	output logic      [11:0] conv_data
);
	logic [3:0] dly_r;
	logic       busy_r;
	logic [7:0] cnt_r;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dly_r <= 4'h0;
			busy_r <= 1'b0;
			cnt_r <= 8'h0;
			conv_done <= 1'b0;
			conv_data <= 12'h0;
		end else begin
			conv_done <= 1'b0;
			// Result lines toggle when no result is offered
			conv_data <= ~conv_data;
			if (conv_start) begin
				busy_r <= 1'b1;
				dly_r <= slow ? 4'h9 : 4'h1;
			end else if (busy_r && dly_r != 4'h0) begin
				dly_r <= dly_r - 4'h1;
			end else if (busy_r) begin
				busy_r <= 1'b0;
				conv_done <= 1'b1;
				conv_data <= {4'h8, cnt_r};
				cnt_r <= cnt_r + 8'h1;
			end
		end
	end
endmodule // sas_conv_model
`default_nettype wire

/* bench/sas_top_checker.sv */
// Port assertions of the converter sequencer
`timescale 1ns/100ps
`default_nettype none
module sas_top_checker (
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        conv_sample,
	input wire logic        conv_start,
	input wire logic [3:0]  conv_chan,
	input wire logic        conv_diff,
	input wire logic [9:0]  buf_full
);
	logic [10:0] len_r;
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n) len_r <= 11'h0;
		else len_r <= conv_sample ? len_r + 11'h1 : 11'h0;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	reset_state_a: assert property ($rose(rst_n) |->
		conv_diff && !conv_sample && buf_full == 10'h0)
		else $error("bad state after reset");
	start_after_a: assert property ($fell(conv_sample) |-> conv_start)
		else $error("no start after sampling");
	start_pulse_a: assert property (conv_start |=> !conv_start)
		else $error("start longer than one cycle");
	one_flight_a: assert property (conv_start |=> !conv_sample)
		else $error("sampling during conversion");
	sample_len_a: assert property ($fell(conv_sample) |->
		(len_r[6:0] == 7'h40 || len_r[6:0] == 7'h60) && len_r < 11'h7e1)
		else $error("sample window length wrong");
	chan_range_a: assert property (conv_start |-> conv_chan < 4'ha)
		else $error("channel slot out of range");
	chan_hold_a: assert property (conv_sample && $past(conv_sample) |->
		$stable(conv_chan) && $stable(conv_diff))
		else $error("selection moved while sampling");
	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside read slot");
	full_clear_a: assert property (|($past(buf_full) & ~buf_full) |->
		$past(reg_wr) || $past(reg_wr, 2))
		else $error("full flag dropped without write");
	cover property (conv_start && conv_chan == 4'h3);
	cover property ($rose(buf_full[0]));
	cover property ($fell(conv_sample) && len_r > 11'h40);
endmodule // sas_top_checker
bind sas_top sas_top_checker i_chk (.ref_clk(ref_clk), .rst_n(rst_n),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.conv_sample(conv_sample), .conv_start(conv_start),
	.conv_chan(conv_chan), .conv_diff(conv_diff), .buf_full(buf_full));
`default_nettype wire

/* bench/tb_sas_top.sv */
// Self-checking bench of the converter sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((e) !== (s)) begin failures++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb_sas_top;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [11:0] reg_addr = 12'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        slow = 1'b0;
	logic        pend = 1'b0;
	logic [31:0] reg_rdata, ev;
	logic        conv_sample, conv_start, conv_diff, conv_neg, conv_done;
	logic [3:0]  conv_chan;
	logic [11:0] conv_data;
	logic [9:0]  buf_full;
	logic [4:0]  ec;
	logic [31:0] seed = 32'd25;
	int          failures = 0;
	int          cmp_count = 0;
	logic [31:0] rq [$];
	logic [4:0]  cq [$];
	logic [31:0] ctl [4] = '{32'h003, 32'h007, 32'h00b, 32'h19b};
	int          gap [4] = '{500, 250, 125, 125};
	logic [5:0]  sel [4] = '{6'h10, 6'h10, 6'h10, 6'h23};
	logic [4:0]  aseq [6] = '{5'h00, 5'h12, 5'h03, 5'h12, 5'h03, 5'h12};
	sas_top i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .conv_sample(conv_sample),
		.conv_start(conv_start), .conv_chan(conv_chan),
		.conv_diff(conv_diff), .conv_neg(conv_neg), .conv_done(conv_done),
		.conv_data(conv_data), .buf_full(buf_full));
	sas_conv_model i_core (.ref_clk(ref_clk), .rst_n(rst_n),
		.conv_start(conv_start), .slow(slow), .conv_done(conv_done),
		.conv_data(conv_data));
	initial forever #12.5 ref_clk = ~ref_clk;
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	// Read notes the expected data; the monitor compares it a cycle later
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= w;
		reg_rd <= !w;
		if (!w) rq.push_back(d);
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
	endtask
	task automatic wait_start(output int n);
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (!conv_start && n < 20000);
	endtask
	task automatic do_reset();
		rst_n <= 1'b0;
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
	endtask
	task automatic wrap_up();
		$display("compares %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		if (pend) begin
			ev = rq.pop_front();
			`CHK("reg_rdata", ev, reg_rdata)
		end
		pend <= reg_rd;
		if (conv_start && cq.size() != 0) begin
			ec = cq.pop_front();
			`CHK("sweep_sel", ec, {conv_diff, conv_chan})
		end
	end
	initial begin
		repeat (40000) @(posedge ref_clk);
		failures++;
		wrap_up();
	end
	initial begin
		int n;
		do_reset();
		`CHK("conv_diff", 1'b1, conv_diff)
		bus(0, 12'h060, 32'h1);
		for (int i = 0; i < 3; i++) begin
			bus(0, 12'h06c + 12'(4 * i), 32'h0);
			seed = xs(seed);
			bus(1, 12'h06c + 12'(4 * i), seed);
			bus(0, 12'h06c + 12'(4 * i), seed);
		end
		bus(1, 12'h010, seed);
		bus(0, 12'h010, 32'h0);
		for (int i = 0; i < 3; i++) bus(1, 12'h06c + 12'(4 * i), 32'h0);
		for (int i = 0; i < 4; i++) begin
			bus(1, 12'h060, ctl[i]);
			wait_start(n);
			`CHK("manual_sel", sel[i], {conv_neg, conv_diff, conv_chan})
			wait_start(n);
			`CHK("pace", gap[i], n)
			bus(1, 12'h060, 32'h1);
		end
		do_reset();
		bus(1, 12'h060, 32'h00b);
		n = 0;
		while (buf_full !== 10'h001 && n < 12000) begin
			@(posedge ref_clk);
			seed = xs(seed);
			slow <= seed[0];
			n++;
		end
		`CHK("buf_full", 10'h001, buf_full)
		bus(1, 12'h060, 32'h1);
		bus(0, 12'h064, 32'h1);
		bus(0, 12'h400, 32'h0801_0800);
		bus(0, 12'h47c, 32'h083f_083e);
		bus(1, 12'h064, 32'h1);
		bus(0, 12'h064, 32'h0);
		do_reset();
		bus(1, 12'h06c, 32'h0000_0050);
		bus(1, 12'h070, 32'h0011_0030);
		for (int i = 0; i < 6; i++) cq.push_back(aseq[i]);
		bus(1, 12'h060, 32'h202);
		n = 0;
		while (cq.size() != 0 && n < 5000) begin
			@(posedge ref_clk);
			n++;
		end
		`CHK("sweep_left", 0, cq.size())
		wrap_up();
	end
endmodule // tb_sas_top
`default_nettype wire
